// ===== hw/host_port_map.svh
// offsets, field positions and reset values of the host port control bank
// assumes byte address = 4 x register index on a 32-bit apb bus
`ifndef HOST_PORT_MAP_SVH
`define HOST_PORT_MAP_SVH

`define IDX_CONTROL_2 4'h2
`define IDX_VID_CONTROL 4'h4
`define IDX_CONTROL_3 4'h6
`define IDX_INGRESS_RATE 4'h8
`define IDX_EGRESS_RATE 4'hA
`define IDX_BANK_SELECT 4'hE

`define BANK_HOST_PORT 6'h34
`define BANK_RESERVED_FIRST 6'h35
`define BANK_RESERVED_LAST 6'h3F
`define BANK_SELECT_RESET 6'h00

`define CR2_RESET 11'h607
`define CR2_RX_ENABLE 9
`define CR2_TX_ENABLE 10
`define CR2_LEARN_OFF 8
`define CR2_SNIFFER 7
`define CR2_RX_SNIFF 6
`define CR2_TX_SNIFF 5
`define CR2_PRIO_CEIL 3
`define CR2_MEMBER_HI 2
`define CR2_MEMBER_LO 0

`define VID_PRIO_HI 15
`define VID_PRIO_LO 13
`define STORE_RESET 16'h0000
`define HOST_PORT_BIT 3'h4

`endif

// ===== hw/host_port_pkg.sv
// types shared by the host port control block
// assumes host_port_map.svh for all numbers
package host_port_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_FETCH = 3'h2,
		ST_ANSWER = 3'h4
	} apb_state_type;
	typedef logic [2:0] port_mask_type;
	typedef logic [2:0] prio_type;
endpackage

// ===== hw/host_port_store.sv
// four 16-bit registers kept like the port-1 set: vid, control 3, ingress and egress rate
// assumes writes and reads are issued by the apb slave in the parent, one per cycle
`timescale 1ns/1ps
`include "host_port_map.svh"
module host_port_store (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire logic [15:0] wr_data,
	input wire logic [1:0] rd_idx,
	output logic [15:0] rd_data_q
);
	logic [15:0] word_q [0:3];
	logic [15:0] rd_data_d;

	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_word
			logic [15:0] word_d;
			always_comb begin
				word_d = word_q[i];
				if (wr_en && wr_idx == 2'(i)) begin
					word_d = wr_data;
				end
			end
			always_ff @(posedge clk_sys) begin
				if (srst) begin
					word_q[i] <= `STORE_RESET;
				end else if (ce) begin
					word_q[i] <= word_d;
				end
			end
		end
	endgenerate

	always_comb begin
		rd_data_d = word_q[rd_idx];
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_data_q <= `STORE_RESET;
		end else if (ce) begin
			rd_data_q <= rd_data_d;
		end
	end
endmodule

// ===== hw/host_port_switch_control.sv
// host port control bank: apb slave, control register 2 and per-packet decisions
// assumes one clock, synchronous inputs, packet descriptors presented one per cycle
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
`include "host_port_map.svh"
module host_port_switch_control (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [5:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pkt_valid,
	input wire logic pkt_egress,
	input wire logic pkt_mon_copy,
	input wire host_port_pkg::prio_type pkt_prio,
	input wire host_port_pkg::port_mask_type pkt_dest,
	input wire host_port_pkg::port_mask_type sniffer_ports,
	output logic res_valid,
	output logic res_drop,
	output logic res_learn,
	output logic res_monitored,
	output host_port_pkg::port_mask_type res_dest,
	output host_port_pkg::prio_type res_prio,
	output logic rx_enable,
	output logic tx_enable,
	output logic sniffer_port
);
	import host_port_pkg::*;

	apb_state_type state_q, state_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic [10:0] cr2_q, cr2_d;
	logic [5:0] bank_q, bank_d;
	prio_type def_prio_q, def_prio_d;
	logic [3:0] idx;
	logic in_host_bank;
	logic store_hit;
	logic [1:0] store_idx;
	logic [2:0] idx_half;
	logic commit;
	logic [15:0] store_rd;

	assign idx = paddr[5:2];
	assign in_host_bank = (bank_q == `BANK_HOST_PORT);
	assign idx_half = idx[3:1] - 3'h2;
	assign store_idx = idx_half[1:0];
	assign store_hit = in_host_bank && !idx[0] && idx >= `IDX_VID_CONTROL
		&& idx <= `IDX_EGRESS_RATE;
	assign commit = (state_q == ST_ANSWER) && psel && penable && pready_q;

	host_port_store u_store (
		.clk_sys(clk_sys),
		.srst(srst),
		.ce(ce),
		.wr_en(commit && pwrite && store_hit),
		.wr_idx(store_idx),
		.wr_data(pwdata[15:0]),
		.rd_idx(store_idx),
		.rd_data_q(store_rd)
	);

	// setup -> fetch (store read settles) -> answer with pready
	always_comb begin
		state_d = state_q;
		prdata_d = prdata_q;
		pready_d = pready_q;
		cr2_d = cr2_q;
		bank_d = bank_q;
		def_prio_d = def_prio_q;
		case (state_q)
			ST_IDLE: begin
				if (psel && !penable) begin
					state_d = ST_FETCH;
				end
			end
			ST_FETCH: begin
				state_d = ST_ANSWER;
				pready_d = 1'b1;
				prdata_d = 32'h0000_0000;
				if (!pwrite) begin
					if (idx == `IDX_BANK_SELECT) begin
						prdata_d = {26'h0, bank_q};
					end else if (in_host_bank && idx == `IDX_CONTROL_2) begin
						prdata_d = {21'h0, cr2_q};
					end else if (store_hit) begin
						prdata_d = {16'h0, store_rd};
					end
				end
			end
			ST_ANSWER: begin
				if (commit) begin
					state_d = ST_IDLE;
					pready_d = 1'b0;
					if (pwrite && idx == `IDX_BANK_SELECT) begin
						bank_d = pwdata[5:0];
					end
					if (pwrite && in_host_bank && idx == `IDX_CONTROL_2) begin
						cr2_d = pwdata[10:0];
					end
					if (pwrite && in_host_bank && idx == `IDX_VID_CONTROL) begin
						def_prio_d = pwdata[`VID_PRIO_HI:`VID_PRIO_LO];
					end
				end
			end
			default: begin
				state_d = ST_IDLE;
				pready_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= ST_IDLE;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			cr2_q <= `CR2_RESET;
			bank_q <= `BANK_SELECT_RESET;
			def_prio_q <= 3'h0;
		end else if (ce) begin
			state_q <= state_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			cr2_q <= cr2_d;
			bank_q <= bank_d;
			def_prio_q <= def_prio_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = 1'b0;
	assign rx_enable = cr2_q[`CR2_RX_ENABLE];
	assign tx_enable = cr2_q[`CR2_TX_ENABLE];
	assign sniffer_port = cr2_q[`CR2_SNIFFER];

	// per-packet decision, one result a cycle after each descriptor
	logic res_valid_q, res_valid_d;
	logic res_drop_q, res_drop_d;
	logic res_learn_q, res_learn_d;
	logic res_mon_q, res_mon_d;
	port_mask_type res_dest_q, res_dest_d;
	prio_type res_prio_q, res_prio_d;
	port_mask_type member;
	port_mask_type copy_to;

	assign member = cr2_q[`CR2_MEMBER_HI:`CR2_MEMBER_LO];
	assign copy_to = sniffer_ports & ~`HOST_PORT_BIT;

	always_comb begin
		res_valid_d = pkt_valid;
		res_drop_d = 1'b0;
		res_learn_d = 1'b0;
		res_mon_d = 1'b0;
		res_dest_d = 3'h0;
		res_prio_d = pkt_prio;
		if (pkt_valid && !pkt_egress) begin
			res_drop_d = !cr2_q[`CR2_RX_ENABLE];
			res_learn_d = cr2_q[`CR2_RX_ENABLE] && !cr2_q[`CR2_LEARN_OFF];
			res_dest_d = pkt_dest & member & ~`HOST_PORT_BIT;
			if (cr2_q[`CR2_RX_SNIFF]) begin
				res_mon_d = 1'b1;
				res_dest_d = res_dest_d | copy_to;
			end
			if (cr2_q[`CR2_PRIO_CEIL] && pkt_prio > def_prio_q) begin
				res_prio_d = def_prio_q;
			end
			if (res_drop_d) begin
				res_dest_d = 3'h0;
				res_mon_d = 1'b0;
			end
		end else if (pkt_valid) begin
			res_drop_d = !cr2_q[`CR2_TX_ENABLE] || (pkt_mon_copy && !cr2_q[`CR2_SNIFFER]);
			res_dest_d = `HOST_PORT_BIT;
			if (cr2_q[`CR2_TX_SNIFF]) begin
				res_mon_d = 1'b1;
				res_dest_d = `HOST_PORT_BIT | copy_to;
			end
			if (res_drop_d) begin
				res_dest_d = 3'h0;
				res_mon_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			res_valid_q <= 1'b0;
			res_drop_q <= 1'b0;
			res_learn_q <= 1'b0;
			res_mon_q <= 1'b0;
			res_dest_q <= 3'h0;
			res_prio_q <= 3'h0;
		end else if (ce) begin
			res_valid_q <= res_valid_d;
			res_drop_q <= res_drop_d;
			res_learn_q <= res_learn_d;
			res_mon_q <= res_mon_d;
			res_dest_q <= res_dest_d;
			res_prio_q <= res_prio_d;
		end
	end

	assign res_valid = res_valid_q;
	assign res_drop = res_drop_q;
	assign res_learn = res_learn_q;
	assign res_monitored = res_mon_q;
	assign res_dest = res_dest_q;
	assign res_prio = res_prio_q;

	// checks
	logic rx_pkt;
	assign rx_pkt = pkt_valid && !pkt_egress;

	rx_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && !cr2_q[`CR2_RX_ENABLE] |=> res_drop && res_dest == 3'h0)
		else $error("received packet not dropped with reception off");
	learn_off_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && cr2_q[`CR2_LEARN_OFF] |=> !res_learn)
		else $error("learning while learning is disabled");
	sniffer_out_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && pkt_valid && pkt_egress && pkt_mon_copy && cr2_q[`CR2_TX_ENABLE]
		|=> res_drop == !$past(cr2_q[`CR2_SNIFFER]))
		else $error("monitored copy handled wrongly for sniffer setting");
	rx_mirror_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && cr2_q[`CR2_RX_ENABLE] && cr2_q[`CR2_RX_SNIFF]
		|=> res_monitored && ((res_dest & $past(copy_to)) == $past(copy_to)))
		else $error("received packet not mirrored");
	tx_mirror_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && pkt_valid && pkt_egress && !pkt_mon_copy && cr2_q[`CR2_TX_ENABLE]
		&& cr2_q[`CR2_TX_SNIFF] |=> res_monitored && res_dest[2])
		else $error("sent packet not mirrored");
	prio_cap_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && cr2_q[`CR2_PRIO_CEIL] |=> res_prio <= $past(def_prio_q)
		&& (res_prio == $past(pkt_prio) || res_prio == $past(def_prio_q)))
		else $error("priority above the ceiling");
	prio_keep_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && pkt_valid && !cr2_q[`CR2_PRIO_CEIL] |=> res_prio == $past(pkt_prio))
		else $error("priority changed with ceiling off");
	reset_value_a: assert property (@(posedge clk_sys)
		srst |=> cr2_q == `CR2_RESET)
		else $error("control register reset value wrong");
	member_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && !cr2_q[`CR2_RX_SNIFF] |=> (res_dest & ~$past(member)) == 3'h0)
		else $error("forwarded outside membership");
	keep_normal_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && cr2_q[`CR2_RX_ENABLE]
		|=> (res_dest & $past(pkt_dest & member & ~`HOST_PORT_BIT))
		== $past(pkt_dest & member & ~`HOST_PORT_BIT))
		else $error("mirror replaced the normal destination");
	reserved_bank_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && state_q == ST_FETCH && !pwrite && bank_q >= `BANK_RESERVED_FIRST
		&& idx != `IDX_BANK_SELECT |=> prdata == 32'h0000_0000)
		else $error("reserved bank read not zero");
	answer_time_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && psel && !penable && state_q == ST_IDLE ##1 ce |=> pready)
		else $error("apb answer not two cycles after setup");
	rx_accept_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && cr2_q[`CR2_RX_ENABLE] |=> !res_drop)
		else $error("received packet dropped with reception on");
	rx_no_learn_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && !cr2_q[`CR2_RX_ENABLE] |=> !res_learn && !res_monitored)
		else $error("refused packet still learned or mirrored");
	learn_on_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && cr2_q[`CR2_RX_ENABLE] && !cr2_q[`CR2_LEARN_OFF] |=> res_learn)
		else $error("no learning while learning is enabled");
	egress_learn_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && pkt_valid && pkt_egress |=> !res_learn)
		else $error("learning from a sent packet");
	rx_plain_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && !cr2_q[`CR2_RX_SNIFF] |=> !res_monitored)
		else $error("received packet marked without receive mirroring");
	tx_plain_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && pkt_valid && pkt_egress && !cr2_q[`CR2_TX_SNIFF] |=> !res_monitored)
		else $error("sent packet marked without transmit mirroring");
	prio_replace_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && cr2_q[`CR2_PRIO_CEIL] && pkt_prio > def_prio_q
		|=> res_prio == $past(def_prio_q))
		else $error("priority above the ceiling not replaced");
	prio_below_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && cr2_q[`CR2_PRIO_CEIL] && pkt_prio <= def_prio_q
		|=> res_prio == $past(pkt_prio))
		else $error("priority at or below the ceiling changed");
	no_host_loop_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt |=> !res_dest[2])
		else $error("received packet sent back to the host port");
	tx_normal_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && pkt_valid && pkt_egress && !pkt_mon_copy && cr2_q[`CR2_TX_ENABLE]
		|=> !res_drop && res_dest[2])
		else $error("sent packet lost its normal destination");
	tx_gate_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && pkt_valid && pkt_egress && !cr2_q[`CR2_TX_ENABLE]
		|=> res_drop && res_dest == 3'h0 && !res_monitored)
		else $error("sent packet passed with transmission off");
	ctrl_write_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && commit && pwrite && in_host_bank && idx == `IDX_CONTROL_2
		|=> cr2_q == $past(pwdata[10:0]))
		else $error("control register write lost");
	bank_write_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && commit && pwrite && idx == `IDX_BANK_SELECT |=> bank_q == $past(pwdata[5:0]))
		else $error("bank select write lost");
	reserved_write_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && commit && pwrite && !in_host_bank && idx != `IDX_BANK_SELECT
		|=> $stable(cr2_q) && $stable(def_prio_q))
		else $error("write in a foreign bank changed the host port");
	bank_read_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && state_q == ST_FETCH && !pwrite && idx == `IDX_BANK_SELECT
		|=> prdata == {26'h0, $past(bank_q)})
		else $error("bank select read back wrong");
	ctrl_read_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && state_q == ST_FETCH && !pwrite && in_host_bank && idx == `IDX_CONTROL_2
		|=> prdata == {21'h0, $past(cr2_q)})
		else $error("control register read back wrong");
	pready_pulse_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && pready |=> !pready)
		else $error("pready longer than one cycle");
	idle_quiet_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && state_q == ST_IDLE |=> !pready)
		else $error("pready without a transfer");
	prdata_hold_a: assert property (@(posedge clk_sys) disable iff (srst)
		ce && state_q != ST_FETCH |=> $stable(prdata))
		else $error("read data changed outside an answer");
	reset_out_a: assert property (@(posedge clk_sys)
		srst |=> !pready && !res_valid && bank_q == `BANK_SELECT_RESET)
		else $error("outputs not at rest after reset");

	rx_mirror_c: cover property (@(posedge clk_sys) disable iff (srst)
		res_valid && !res_drop && res_monitored && res_learn);
	prio_cap_c: cover property (@(posedge clk_sys) disable iff (srst)
		ce && rx_pkt && cr2_q[`CR2_PRIO_CEIL] && pkt_prio > def_prio_q);
	bank_write_c: cover property (@(posedge clk_sys) disable iff (srst)
		commit && pwrite && idx == `IDX_BANK_SELECT && bank_q >= `BANK_RESERVED_FIRST);
	store_read_c: cover property (@(posedge clk_sys) disable iff (srst)
		commit && !pwrite && store_hit);
	sniffer_copy_c: cover property (@(posedge clk_sys) disable iff (srst)
		ce && pkt_valid && pkt_egress && pkt_mon_copy && cr2_q[`CR2_SNIFFER]);
endmodule

// ===== test/testbench.sv
// self-checking bench for the host port control bank: apb registers and packet decisions
// assumes the hw/ files are compiled first; one 10 MHz clock with synchronous reset
`timescale 1ns/1ps
`include "host_port_map.svh"
module testbench;
	import host_port_pkg::*;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [5:0] paddr = 6'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic pkt_valid = 1'b0;
	logic pkt_egress = 1'b0;
	logic pkt_mon_copy = 1'b0;
	prio_type pkt_prio = 3'h0;
	port_mask_type pkt_dest = 3'h0;
	port_mask_type sniffer_ports = 3'h0;
	logic res_valid, res_drop, res_learn, res_monitored, rx_enable, tx_enable, sniffer_port;
	port_mask_type res_dest;
	prio_type res_prio;
	integer mismatches = 0;
	integer samples_checked = 0;
	logic [10:0] c2_m = `CR2_RESET;
	logic [15:0] vid_m = 16'h0000;
	logic [31:0] rdv, r;
	logic perr;
	logic [3:0] st_idx [4] = '{4'h4, 4'h6, 4'h8, 4'hA};

	host_port_switch_control DUT (.clk_sys(clk_sys), .srst(srst), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_egress(pkt_egress),
		.pkt_mon_copy(pkt_mon_copy), .pkt_prio(pkt_prio), .pkt_dest(pkt_dest),
		.sniffer_ports(sniffer_ports), .res_valid(res_valid), .res_drop(res_drop),
		.res_learn(res_learn), .res_monitored(res_monitored), .res_dest(res_dest),
		.res_prio(res_prio), .rx_enable(rx_enable), .tx_enable(tx_enable),
		.sniffer_port(sniffer_port));

	initial begin
		forever #50 clk_sys = ~clk_sys;
	end

	task print_verdict;
		if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			mismatches = mismatches + 1;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task apb(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
		integer n;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n = n + 1;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			mismatches = mismatches + 1;
			print_verdict;
		end
		rdv = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdchk(input logic [3:0] idx, input logic [31:0] exp);
		apb(1'b0, idx, 32'h0);
		chk(rdv, exp);
		chk(perr, 0);
	endtask

	task pkt(input logic eg, input logic mc, input prio_type pr, input port_mask_type ds,
		input port_mask_type sn);
		logic drop;
		logic mon;
		port_mask_type dst;
		prio_type pe;
		@(posedge clk_sys);
		pkt_valid <= 1'b1;
		pkt_egress <= eg;
		pkt_mon_copy <= mc;
		pkt_prio <= pr;
		pkt_dest <= ds;
		sniffer_ports <= sn;
		@(posedge clk_sys);
		pkt_valid <= 1'b0;
		#1;
		chk(res_valid, 1);
		chk(rx_enable, c2_m[9]);
		chk(tx_enable, c2_m[10]);
		chk(sniffer_port, c2_m[7]);
		if (!eg) begin
			drop = !c2_m[9];
			dst = drop ? 3'h0 : (ds & c2_m[2:0] & 3'h3) | (c2_m[6] ? sn & 3'h3 : 3'h0);
			mon = !drop && c2_m[6];
			pe = (c2_m[3] && pr > vid_m[15:13]) ? vid_m[15:13] : pr;
			chk(res_drop, drop);
			chk(res_learn, !drop && !c2_m[8]);
			chk(res_dest, dst);
			chk(res_monitored, mon);
			if (!drop) chk(res_prio, pe);
		end else begin
			drop = !c2_m[10] || (mc && !c2_m[7]);
			chk(res_drop, drop);
			chk(res_learn, 0);
			if (!drop) begin
				chk(res_dest, 3'h4 | (c2_m[5] ? sn & 3'h3 : 3'h0));
				chk(res_monitored, c2_m[5]);
				chk(res_prio, pr);
			end else begin
				chk(res_dest, 3'h0);
				chk(res_monitored, 0);
			end
		end
	endtask

	initial begin
		void'($urandom(21780));
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		#1;
		chk(tx_enable, 1);
		chk(sniffer_port, 0);
		rdchk(4'hE, `BANK_SELECT_RESET);
		rdchk(4'h2, 0);
		apb(1'b1, 4'hE, 32'h34);
		rdchk(4'h2, `CR2_RESET);
		foreach (st_idx[i]) begin
			rdchk(st_idx[i], 0);
			r = $urandom;
			apb(1'b1, st_idx[i], r);
			if (st_idx[i] == 4'h4) vid_m = r[15:0];
			rdchk(st_idx[i], {16'h0, r[15:0]});
		end
		apb(1'b1, 4'hC, $urandom);
		rdchk(4'hC, 0);
		for (int b = 53; b <= 63; b++) begin
			apb(1'b1, 4'hE, b);
			rdchk(4'hE, b);
			apb(1'b1, 4'h2, 32'h0);
			rdchk(4'h2, 0);
			rdchk(4'h4, 0);
		end
		apb(1'b1, 4'hE, 32'h34);
		rdchk(4'h2, {21'h0, c2_m});
		for (int i = 0; i < 160; i++) begin
			if (i % 4 == 0) begin
				r = $urandom;
				c2_m = r[10:0];
				vid_m = r[31:16];
				apb(1'b1, 4'h2, {21'h0, c2_m});
				apb(1'b1, 4'h4, {16'h0, vid_m});
				rdchk(4'h2, {21'h0, c2_m});
			end
			r = $urandom;
			pkt(r[0], r[1], r[4:2], r[7:5], r[10:8]);
		end
		print_verdict;
	end
endmodule
